// *** common/rcmi_pkg.sv ***
// rcmi_pkg: constants, carriers and state codes for the reset / clock / strap block
// assumes a single 20 MHz clock that stands in for the core clock; all straps synchronous
`default_nettype none
package rcmi_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int PLL_LOCK_NS = 10000;
    localparam int PLL_LOCK_CYCLES = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [8:0] PLL_LOCK_LAST = 9'(PLL_LOCK_CYCLES - 1);
    localparam logic [4:0] COLD_HOLD_MIN = 5'h10;
    localparam logic [8:0] RESET_CMD = 9'h1d0;
    localparam logic [31:0] RESET_VECTOR = 32'hbfc00000;
    localparam logic [31:0] IDLE_AD = 32'h00000000;
    localparam logic [1:0] RATIO_X2 = 2'h0;
    localparam logic [1:0] RATIO_X2P5 = 2'h1;
    localparam logic [1:0] RATIO_X3 = 2'h2;
    localparam logic [1:0] RATIO_X4 = 2'h3;
    localparam logic [2:0] DIV_CNT_RESET = 3'h0;

    typedef enum logic [3:0] {
        ST_PLL = 4'h1,
        ST_LOCK = 4'h2,
        ST_HOLD = 4'h4,
        ST_RUN = 4'h8
    } rcmi_state_t;

    typedef struct packed {
        logic [8:0] sys_command_bus;
        logic out_valid_n;
        logic release_n;
        logic [31:0] sys_addr_data_bus;
        logic ad_oe_n;
    } rcmi_bus_t;

    typedef struct packed {
        logic legacy_protocol;
        logic [1:0] ratio;
        logic big_endian;
        logic timer_irq_en;
    } rcmi_strap_t;

    localparam rcmi_bus_t BUS_RESET = '{RESET_CMD, 1'b1, 1'b1, IDLE_AD, 1'b0};
    localparam rcmi_strap_t STRAP_RESET = '{1'b0, RATIO_X2, 1'b0, 1'b1};
endpackage
`default_nettype wire

// *** verilog/rcmi_clk_div.sv ***
// rcmi_clk_div: bus clock enable derived from the core clock by the selected ratio
// assumes restart is held until the pll locks and pulsed at cold release; it runs free while the core is held
`default_nettype none
module rcmi_clk_div (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic restart,
    input wire logic [1:0] ratio,
    output logic tick
);
    logic [2:0] cnt_q, cnt_d;
    logic phase_q, phase_d;

    // last count of one bus period; 2.5 alternates periods of 2 and 3 core cycles
    function automatic logic [2:0] last_count(input logic [1:0] r, input logic ph);
        logic [2:0] res;
        res = 3'h1;
        case (r)
            rcmi_pkg::RATIO_X2: res = 3'h1;
            rcmi_pkg::RATIO_X2P5: res = ph ? 3'h2 : 3'h1;
            rcmi_pkg::RATIO_X3: res = 3'h2;
            rcmi_pkg::RATIO_X4: res = 3'h3;
            default: res = 3'h1;
        endcase
        return res;
    endfunction

    always_comb begin
        tick = (cnt_q == rcmi_pkg::DIV_CNT_RESET);
        phase_d = phase_q;
        if (restart) begin
            // restart puts the count at zero so the first bus edge is the first after release
            cnt_d = rcmi_pkg::DIV_CNT_RESET;
            phase_d = 1'b0;
        end else if (tick) begin
            cnt_d = last_count(ratio, phase_q);
            phase_d = ~phase_q;
        end else begin
            cnt_d = cnt_q - 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_q <= rcmi_pkg::DIV_CNT_RESET;
            phase_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            phase_q <= phase_d;
        end
    end
endmodule
`default_nettype wire

// *** verilog/rcmi_top.sv ***
// rcmi_top: power-on and cold reset sequencing, bus idle drive, bus clock enable, strap capture
// assumes clk is the core clock; pll_reset_n and cold_reset_n may be fully asynchronous to it
`default_nettype none
module rcmi_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pll_reset_n,
    input wire logic cold_reset_n,
    input wire logic bus_protocol_select,
    input wire logic [1:0] clock_ratio_select,
    input wire logic byte_order_pin,
    input wire logic timer_irq_disable_n,
    input wire logic reverse_user_endian,
    input wire logic user_mode,
    input wire rcmi_pkg::rcmi_bus_t core_bus,
    output var rcmi_pkg::rcmi_bus_t sys_bus_q,
    output var rcmi_pkg::rcmi_strap_t strap_q,
    output logic big_endian_flag_q,
    output logic eff_big_endian_q,
    output logic core_run_q,
    output logic bus_tick_q,
    output logic fetch_req_q,
    output logic [31:0] fetch_addr_q,
    output logic pll_locked_q,
    output logic hold_short_q,
    output logic strap_changed_q
);
    rcmi_pkg::rcmi_state_t state_q, state_d;
    logic [1:0] pll_sync_q, pll_sync_d;
    logic [1:0] cold_sync_q, cold_sync_d;
    logic [8:0] lock_cnt_q, lock_cnt_d;
    logic [4:0] hold_cnt_q, hold_cnt_d;
    rcmi_pkg::rcmi_bus_t sys_bus_d;
    rcmi_pkg::rcmi_strap_t strap_d, strap_pins;
    logic big_endian_flag_d, eff_big_endian_d, core_run_d, bus_tick_d;
    logic fetch_req_d, pll_locked_d, hold_short_d, strap_changed_d;
    logic [31:0] fetch_addr_d;
    logic release_now, div_restart, div_tick;
    logic [1:0] div_ratio;

    // input synchronisers: first stage feeds only the second
    always_comb begin
        pll_sync_d = {pll_sync_q[0], pll_reset_n};
        cold_sync_d = {cold_sync_q[0], cold_reset_n};
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pll_sync_q <= 2'h0;
            cold_sync_q <= 2'h0;
        end else begin
            pll_sync_q <= pll_sync_d;
            cold_sync_q <= cold_sync_d;
        end
    end

    assign strap_pins = '{bus_protocol_select == 1'b0, clock_ratio_select, byte_order_pin, ~timer_irq_disable_n};
    assign release_now = (state_q == rcmi_pkg::ST_HOLD) && cold_sync_q[1] && pll_sync_q[1];
    // divider stays parked until locked, then restarts exactly at cold release
    assign div_restart = (state_q == rcmi_pkg::ST_PLL) || (state_q == rcmi_pkg::ST_LOCK) || release_now;
    assign div_ratio = (state_q == rcmi_pkg::ST_RUN) ? strap_q.ratio : clock_ratio_select;

    rcmi_clk_div u_div (
        .clk(clk),
        .rst_b(rst_b),
        .restart(div_restart),
        .ratio(div_ratio),
        .tick(div_tick)
    );

    // sequencing state
    always_comb begin
        state_d = state_q;
        lock_cnt_d = lock_cnt_q;
        hold_cnt_d = hold_cnt_q;
        pll_locked_d = pll_locked_q;
        hold_short_d = hold_short_q;
        if (!pll_sync_q[1]) begin
            // pll reset wins over everything and restarts lock timing
            state_d = rcmi_pkg::ST_PLL;
            lock_cnt_d = 9'h000;
            hold_cnt_d = 5'h00;
            pll_locked_d = 1'b0;
        end else begin
            case (state_q)
                rcmi_pkg::ST_PLL: begin
                    state_d = rcmi_pkg::ST_LOCK;
                end
                rcmi_pkg::ST_LOCK: begin
                    if (lock_cnt_q == rcmi_pkg::PLL_LOCK_LAST) begin
                        state_d = rcmi_pkg::ST_HOLD;
                        pll_locked_d = 1'b1;
                    end else begin
                        lock_cnt_d = lock_cnt_q + 9'h001;
                    end
                end
                rcmi_pkg::ST_HOLD: begin
                    if (cold_sync_q[1]) begin
                        // clocks start with the release; short holds are only reported
                        state_d = rcmi_pkg::ST_RUN;
                        hold_short_d = hold_short_q || (hold_cnt_q < rcmi_pkg::COLD_HOLD_MIN);
                    end else if (div_tick && hold_cnt_q != rcmi_pkg::COLD_HOLD_MIN) begin
                        hold_cnt_d = hold_cnt_q + 5'h01;
                    end
                end
                rcmi_pkg::ST_RUN: begin
                    if (!cold_sync_q[1]) begin
                        state_d = rcmi_pkg::ST_HOLD;
                        hold_cnt_d = 5'h00;
                    end
                end
                default: begin
                    state_d = rcmi_pkg::ST_PLL;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= rcmi_pkg::ST_PLL;
            lock_cnt_q <= 9'h000;
            hold_cnt_q <= 5'h00;
            pll_locked_q <= 1'b0;
            hold_short_q <= 1'b0;
        end else begin
            state_q <= state_d;
            lock_cnt_q <= lock_cnt_d;
            hold_cnt_q <= hold_cnt_d;
            pll_locked_q <= pll_locked_d;
            hold_short_q <= hold_short_d;
        end
    end

    // bus drive, straps, fetch and clock enables
    always_comb begin
        sys_bus_d = sys_bus_q;
        strap_d = strap_q;
        strap_changed_d = strap_changed_q;
        fetch_req_d = release_now;
        fetch_addr_d = release_now ? rcmi_pkg::RESET_VECTOR : fetch_addr_q;
        core_run_d = (state_d == rcmi_pkg::ST_RUN);
        bus_tick_d = div_tick && (state_q == rcmi_pkg::ST_RUN);
        if (state_q != rcmi_pkg::ST_RUN) begin
            // own the bus and hold it idle; agents mid-transfer must be reset by the system
            sys_bus_d = rcmi_pkg::BUS_RESET;
        end else if (div_tick) begin
            sys_bus_d = core_bus;
        end
        if (release_now) begin
            strap_d = strap_pins;
        end else if (state_q == rcmi_pkg::ST_RUN) begin
            // straps are not re-read; a late protocol, ratio or timer strap change is flagged, not followed; byte order is not flagged
            strap_changed_d = strap_changed_q || (strap_pins.legacy_protocol != strap_q.legacy_protocol)
                || (strap_pins.ratio != strap_q.ratio) || (strap_pins.timer_irq_en != strap_q.timer_irq_en);
        end
        big_endian_flag_d = strap_d.big_endian;
        eff_big_endian_d = strap_d.big_endian ^ (reverse_user_endian & user_mode);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sys_bus_q <= rcmi_pkg::BUS_RESET;
            strap_q <= rcmi_pkg::STRAP_RESET;
            strap_changed_q <= 1'b0;
            fetch_req_q <= 1'b0;
            fetch_addr_q <= rcmi_pkg::RESET_VECTOR;
            core_run_q <= 1'b0;
            bus_tick_q <= 1'b0;
            big_endian_flag_q <= 1'b0;
            eff_big_endian_q <= 1'b0;
        end else begin
            sys_bus_q <= sys_bus_d;
            strap_q <= strap_d;
            strap_changed_q <= strap_changed_d;
            fetch_req_q <= fetch_req_d;
            fetch_addr_q <= fetch_addr_d;
            core_run_q <= core_run_d;
            bus_tick_q <= bus_tick_d;
            big_endian_flag_q <= big_endian_flag_d;
            eff_big_endian_q <= eff_big_endian_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_release;
        (state_q == rcmi_pkg::ST_HOLD) && cold_sync_q[1] && pll_sync_q[1];
    endsequence

    sequence s_idle_bus;
        sys_bus_q.sys_command_bus == rcmi_pkg::RESET_CMD && sys_bus_q.out_valid_n && sys_bus_q.release_n
            && !sys_bus_q.ad_oe_n;
    endsequence

    property p_pll_reset;
        !pll_sync_q[1] |=> state_q == rcmi_pkg::ST_PLL && !pll_locked_q;
    endproperty
    a_pll_reset: assert property (p_pll_reset) else $error("pll reset did not restart sequencing");

    property p_pll_sample;
        !pll_reset_n ##1 !pll_reset_n |=> !pll_sync_q[1];
    endproperty
    a_pll_sample: assert property (p_pll_sample) else $error("pll reset not seen two cycles later");

    property p_cold_enter;
        (state_q == rcmi_pkg::ST_RUN) && pll_sync_q[1] && !cold_sync_q[1] |=> state_q == rcmi_pkg::ST_HOLD;
    endproperty
    a_cold_enter: assert property (p_cold_enter) else $error("cold reset did not stop the core");

    property p_cold_sample;
        !cold_reset_n ##1 !cold_reset_n |=> !cold_sync_q[1];
    endproperty
    a_cold_sample: assert property (p_cold_sample) else $error("cold reset not seen two cycles later");

    property p_idle_bus;
        (state_q != rcmi_pkg::ST_RUN) |=> s_idle_bus;
    endproperty
    a_idle_bus: assert property (p_idle_bus) else $error("bus not idle during cold reset");

    property p_fetch;
        s_release |=> fetch_req_q && core_run_q && fetch_addr_q == rcmi_pkg::RESET_VECTOR ##1 !fetch_req_q;
    endproperty
    a_fetch: assert property (p_fetch) else $error("reset vector fetch missing after release");

    property p_first_tick;
        s_release |=> !bus_tick_q ##1 bus_tick_q;
    endproperty
    a_first_tick: assert property (p_first_tick) else $error("first bus edge not aligned to release");

    property p_ratio4;
        (state_q == rcmi_pkg::ST_RUN) && strap_q.ratio == rcmi_pkg::RATIO_X4 && bus_tick_q && cold_sync_q[1]
            && pll_sync_q[1] ##1 cold_sync_q[1] && pll_sync_q[1] ##1 cold_sync_q[1] && pll_sync_q[1]
            |-> !bus_tick_q ##1 !bus_tick_q ##1 bus_tick_q;
    endproperty
    a_ratio4: assert property (p_ratio4) else $error("bus period wrong at ratio 4");

    property p_straps;
        s_release |=> strap_q == $past(strap_pins) && big_endian_flag_q == $past(byte_order_pin);
    endproperty
    a_straps: assert property (p_straps) else $error("straps not captured at release");

    property p_user_endian;
        (state_q == rcmi_pkg::ST_RUN) && reverse_user_endian && user_mode && cold_sync_q[1] && pll_sync_q[1]
            |=> eff_big_endian_q != big_endian_flag_q;
    endproperty
    a_user_endian: assert property (p_user_endian) else $error("user byte order not reversed");
endmodule
`default_nettype wire

// *** tb/rcmi_board_model.sv ***
// rcmi_board_model: board reset circuitry driving the pll and cold reset pins
// assumes clk is the reference clock; pin edges land 5 ns after the rising edge on purpose
`default_nettype none
module rcmi_board_model (
    input wire logic clk,
    output logic pll_reset_n,
    output logic cold_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // both resets are held from power-on until the bench sequences them
    initial begin
        pll_reset_n = 1'b0;
        cold_reset_n = 1'b0;
    end

    // pins move the same small step after the edge as every other bench input
    task automatic set_pll(input logic v);
        @(posedge clk);
        #5;
        pll_reset_n = v;
    endtask

    task automatic set_cold(input logic v);
        @(posedge clk);
        #5;
        cold_reset_n = v;
    endtask
endmodule
`default_nettype wire

// *** tb/reset_clock_mode_init_test.sv ***
// reset_clock_mode_init_test: self-checking bench for rcmi_top
// assumes rcmi_board_model owns the reset pins; straps and core bus are driven here
`default_nettype none
module reset_clock_mode_init_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        rcmi_pkg::rcmi_strap_t strap;
        logic eff;
        int gap1;
        int gap2;
        rcmi_pkg::rcmi_bus_t bus;
    } rcmi_exp_t;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    wire pll_reset_n;
    wire cold_reset_n;
    logic bus_protocol_select = 1'b0;
    logic [1:0] clock_ratio_select = 2'h0;
    logic byte_order_pin = 1'b0;
    logic timer_irq_disable_n = 1'b0;
    logic reverse_user_endian = 1'b0;
    logic user_mode = 1'b0;
    rcmi_pkg::rcmi_bus_t core_bus = '0;
    rcmi_pkg::rcmi_bus_t sys_bus_q;
    rcmi_pkg::rcmi_strap_t strap_q;
    logic big_endian_flag_q, eff_big_endian_q, core_run_q, bus_tick_q, fetch_req_q;
    logic pll_locked_q, hold_short_q, strap_changed_q;
    logic [31:0] fetch_addr_q;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int nt = 3;
    int fetch_cyc = 0;
    int tick_cyc [3];
    int g1 [4] = '{2, 2, 3, 4};
    int g2 [4] = '{2, 3, 3, 4};
    rcmi_exp_t exp_q [$];
    rcmi_exp_t cur;

    always #25 clk = ~clk;

    rcmi_board_model board_u (.clk(clk), .pll_reset_n(pll_reset_n), .cold_reset_n(cold_reset_n));

    rcmi_top dut_u (.clk(clk), .rst_b(rst_b), .pll_reset_n(pll_reset_n), .cold_reset_n(cold_reset_n),
        .bus_protocol_select(bus_protocol_select), .clock_ratio_select(clock_ratio_select),
        .byte_order_pin(byte_order_pin), .timer_irq_disable_n(timer_irq_disable_n),
        .reverse_user_endian(reverse_user_endian), .user_mode(user_mode), .core_bus(core_bus),
        .sys_bus_q(sys_bus_q), .strap_q(strap_q), .big_endian_flag_q(big_endian_flag_q),
        .eff_big_endian_q(eff_big_endian_q), .core_run_q(core_run_q), .bus_tick_q(bus_tick_q),
        .fetch_req_q(fetch_req_q), .fetch_addr_q(fetch_addr_q), .pll_locked_q(pll_locked_q),
        .hold_short_q(hold_short_q), .strap_changed_q(strap_changed_q));

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_of_test();
        if (num_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask

    // set_straps only moves straps while the core is held; a sweep covers every ratio and mode
    task automatic set_straps(input int i);
        logic [63:0] r;
        r = {$urandom, $urandom};
        bus_protocol_select = i[2];
        clock_ratio_select = i[1:0];
        timer_irq_disable_n = r[47];
        byte_order_pin = r[48];
        reverse_user_endian = r[45];
        user_mode = r[46];
        core_bus = r[43:0];
    endtask

    task automatic launch();
        rcmi_exp_t e;
        e.strap = '{~bus_protocol_select, clock_ratio_select, byte_order_pin, ~timer_irq_disable_n};
        e.eff = byte_order_pin ^ (reverse_user_endian & user_mode);
        e.gap1 = g1[clock_ratio_select];
        e.gap2 = g2[clock_ratio_select];
        e.bus = core_bus;
        exp_q.push_back(e);
        board_u.set_cold(1'b1);
    endtask

    // outputs are read half a cycle after the edge that updates them
    always @(negedge clk) begin
        cyc++;
        if (rst_b === 1'b1 && fetch_req_q === 1'b1) begin
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("BAD fetch_req_q expected 0 seen 1");
            end else begin
                cur = exp_q.pop_front();
                chk("strap_q", cur.strap, strap_q);
                chk("big_endian_flag_q", cur.strap.big_endian, big_endian_flag_q);
                chk("eff_big_endian_q", cur.eff, eff_big_endian_q);
                chk("fetch_addr_q", rcmi_pkg::RESET_VECTOR, fetch_addr_q);
                chk("core_run_q", 1, core_run_q);
                fetch_cyc = cyc;
                nt = 0;
            end
        end else if (bus_tick_q === 1'b1 && nt < 3) begin
            tick_cyc[nt] = cyc;
            nt++;
            if (nt == 3) begin
                chk("first tick", fetch_cyc + 1, tick_cyc[0]);
                chk("tick gap 1", cur.gap1, tick_cyc[1] - tick_cyc[0]);
                chk("tick gap 2", cur.gap2, tick_cyc[2] - tick_cyc[1]);
                chk("sys_bus_q", cur.bus, sys_bus_q);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("BAD watchdog expected done seen timeout");
        end_of_test();
    end

    initial begin
        void'($urandom(32'h8c465f4d));
        cycles(4);
        rst_b = 1'b1;
        cycles(2);
        chk("sys_bus_q", rcmi_pkg::BUS_RESET, sys_bus_q);
        chk("fetch_addr_q", rcmi_pkg::RESET_VECTOR, fetch_addr_q);
        cycles(20);
        board_u.set_pll(1'b1);
        cycles(250);
        for (int i = 0; i < 8; i++) begin
            set_straps(i);
            cycles(80);
            chk("sys_bus_q", rcmi_pkg::BUS_RESET, sys_bus_q);
            launch();
            cycles(30);
            if (i < 7) begin
                board_u.set_cold(1'b0);
                cycles(4);
            end
        end
        chk("hold_short_q", 0, hold_short_q);
        chk("strap_changed_q", 0, strap_changed_q);
        bus_protocol_select = ~bus_protocol_select;
        cycles(4);
        chk("strap_changed_q", 1, strap_changed_q);
        board_u.set_cold(1'b0);
        board_u.set_pll(1'b0);
        cycles(8);
        chk("core_run_q", 0, core_run_q);
        chk("pll_locked_q", 0, pll_locked_q);
        chk("sys_bus_q", rcmi_pkg::BUS_RESET, sys_bus_q);
        set_straps(5);
        board_u.set_pll(1'b1);
        cycles(20);
        // cold released long before the multiplier settles: start must wait for lock
        launch();
        cycles(100);
        chk("core_run_q", 0, core_run_q);
        cycles(150);
        chk("core_run_q", 1, core_run_q);
        chk("pll_locked_q", 1, pll_locked_q);
        chk("hold_short_q", 1, hold_short_q);
        chk("pending notes", 0, exp_q.size());
        end_of_test();
    end
endmodule
`default_nettype wire
